// ==== src/monitor_irq_config.sv ====
// Interrupt enable, pin select and configuration registers of the monitor.
`include "irq_cfg_map.svh"
module monitor_irq_config
   import irq_cfg_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        wr_en_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       rdata_o,
   output logic             hit_o,
   input  wire logic        lock_i,
   input  wire logic        global_irq_output_enable_i,
   input  wire logic        thermal_readings_valid_i,
   input  wire logic [4:0]  volt_event_i,
   input  wire logic [3:0]  speed_event_i,
   input  wire logic [2:0]  temp_event_i,
   input  wire logic [4:0]  volt_status_i,
   input  wire logic [3:0]  speed_status_i,
   input  wire logic [2:0]  temp_status_i,
   input  wire logic [23:0] drive_duty_i,
   input  wire logic [2:0]  fan_enabled_i,
   input  wire logic [63:0] tach_min_i,
   output logic [4:0]       volt_status_set_o,
   output logic [3:0]       speed_status_set_o,
   output logic [2:0]       temp_status_set_o,
   output logic [7:0]       speed_input_drive_association_o,
   output logic             spinup_shortening_enable_o,
   output logic             soft_reset_o,
   output logic             speed3_pin_as_irq_o,
   output logic             drive2_pin_as_irq_o,
   output logic             irq_n_o,
   output logic             irq_n_oe_o
);
   import irq_cfg_pkg::*;

   // --------------------------------------------------------------
   // Register storage.
   // --------------------------------------------------------------
   reg8_t voltage_event_enable;
   reg8_t device_configuration;
   reg8_t fan_speed_event_enable;
   reg8_t speed_input_drive_association;
   reg8_t temperature_event_enable;
   logic  init_pulse;
   logic  wr_ok;

   // Decide whether a write reaches storage at this address.
   function automatic logic wr_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
      wr_hit = wr_en_i && wr_ok && (a == ofs);
   endfunction : wr_hit

   // Writes reach storage only while the lock is open.
   assign wr_ok = !lock_i;

   // Voltage enable register, reserved bits stay zero.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         voltage_event_enable <= `VOLT_EN_RST;
      end else if (init_pulse) begin
         voltage_event_enable <= `VOLT_EN_RST;
      end else if (wr_hit(addr_i, `VOLT_EN_OFS)) begin
         voltage_event_enable <= wdata_i & `VOLT_EN_WMASK;
      end
   end

   // Fan speed enable register.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fan_speed_event_enable <= `FAN_EN_RST;
      end else if (init_pulse) begin
         fan_speed_event_enable <= `FAN_EN_RST;
      end else if (wr_hit(addr_i, `FAN_EN_OFS)) begin
         fan_speed_event_enable <= wdata_i & `FAN_EN_WMASK;
      end
   end

   // Association register, every code is stored as written.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         speed_input_drive_association <= `ASSOC_RST;
      end else if (init_pulse) begin
         speed_input_drive_association <= `ASSOC_RST;
      end else if (wr_hit(addr_i, `ASSOC_OFS)) begin
         speed_input_drive_association <= wdata_i;
      end
   end

   // Temperature enable register.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         temperature_event_enable <= `TEMP_EN_RST;
      end else if (init_pulse) begin
         temperature_event_enable <= `TEMP_EN_RST;
      end else if (wr_hit(addr_i, `TEMP_EN_OFS)) begin
         temperature_event_enable <= wdata_i & `TEMP_EN_WMASK;
      end
   end

   // Configuration register; the ready bit is live, not stored.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         device_configuration <= `DEV_CFG_RST;
      end else if (init_pulse) begin
         device_configuration <= `DEV_CFG_RST;
      end else if (wr_hit(addr_i, `DEV_CFG_OFS)) begin
         device_configuration <= wdata_i & `CFG_WMASK;
      end
   end

   // --------------------------------------------------------------
   // Soft reset.
   // --------------------------------------------------------------
   // A write of one to the init bit gives a one-cycle reset pulse.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         init_pulse <= 1'b0;
      end else begin
         init_pulse <= wr_hit(addr_i, `DEV_CFG_OFS)
                       && wdata_i[`CFG_INIT_BIT];
      end
   end

   assign soft_reset_o = init_pulse;

   // --------------------------------------------------------------
   // Read path.
   // --------------------------------------------------------------
   // Decode the read address; unmapped addresses read zero.
   always_comb begin
      rdata_o = 8'h00;
      hit_o   = 1'b1;
      if (addr_i == `VOLT_EN_OFS) begin
         rdata_o = voltage_event_enable;
      end else if (addr_i == `DEV_CFG_OFS) begin
         rdata_o = device_configuration;
         rdata_o[`CFG_READY_BIT] = thermal_readings_valid_i;
         rdata_o[`CFG_INIT_BIT]  = 1'b0;
      end else if (addr_i == `FAN_EN_OFS) begin
         rdata_o = fan_speed_event_enable;
      end else if (addr_i == `ASSOC_OFS) begin
         rdata_o = speed_input_drive_association;
      end else if (addr_i == `TEMP_EN_OFS) begin
         rdata_o = temperature_event_enable;
      end else begin
         hit_o = 1'b0;
      end
   end

   // --------------------------------------------------------------
   // Status set gating.
   // --------------------------------------------------------------
   logic [4:0] volt_en;
   // Voltage enables: 2.5V, core, 5V, 12V and main supply.
   assign volt_en = {voltage_event_enable[7:5],
                     voltage_event_enable[3:2]};
   assign volt_status_set_o = volt_event_i & volt_en;
   assign temp_status_set_o = temp_event_i
                              & temperature_event_enable[3:1];

   // One suppression gate per fan speed input.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_speed
         speed_event_gate u_gate (
            .event_i       (speed_event_i[g]),
            .enable_i      (fan_speed_event_enable[g+1]),
            .assoc_i       (speed_input_drive_association[2*g+1:2*g]),
            .drive_duty_i  (drive_duty_i),
            .fan_enabled_i (fan_enabled_i),
            .tach_min_i    (tach_min_i[16*g+15:16*g]),
            .set_o         (speed_status_set_o[g])
         );
      end
   endgenerate

   assign speed_input_drive_association_o = speed_input_drive_association;
   assign spinup_shortening_enable_o =
      device_configuration[`CFG_SPINUP_BIT];
   assign speed3_pin_as_irq_o =
      device_configuration[`CFG_SPEED3_BIT];
   assign drive2_pin_as_irq_o =
      device_configuration[`CFG_DRIVE2_BIT];

   // --------------------------------------------------------------
   // Interrupt pin.
   // --------------------------------------------------------------
   logic v_req;
   logic s_req;
   logic t_req;
   logic irq_req;
   assign v_req = voltage_event_enable[`GROUP_EN_BIT]
                  && |(volt_status_i & volt_en);
   // Each group needs its group bit and one individually enabled status.
   assign s_req = fan_speed_event_enable[`GROUP_EN_BIT]
                  && |(speed_status_i & fan_speed_event_enable[4:1]);
   assign t_req = temperature_event_enable[`GROUP_EN_BIT]
                  && |(temp_status_i & temperature_event_enable[3:1]);
   assign irq_req = global_irq_output_enable_i
                    && (v_req || s_req || t_req);

   // Registered open-drain drive: low only in the cycle after a request stands.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_n_oe_o <= 1'b0;
      end else begin
         irq_n_oe_o <= irq_req;
      end
   end

   assign irq_n_o = 1'b0;

   // --------------------------------------------------------------
   // Checks.
   // --------------------------------------------------------------
   // Locked writes leave every enable, select and association unchanged.
   locked_write_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      lock_i && !init_pulse |=> $stable(voltage_event_enable)
         && $stable(temperature_event_enable))
      else $error("Enable register changed while locked.");
   locked_rest_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      lock_i && !init_pulse |=> $stable(device_configuration)
         && $stable(fan_speed_event_enable)
         && $stable(speed_input_drive_association))
      else $error("Register changed while locked.");
   // Individual enables gate the status set strobes.
   volt_gate_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      volt_status_set_o[0] |-> voltage_event_enable[2])
      else $error("Voltage status set while disabled.");
   temp_gate_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (temp_status_set_o & ~temperature_event_enable[3:1]) == 3'h0)
      else $error("Temperature status set while disabled.");
   speed_gate_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      speed_status_set_o[0] |-> fan_speed_event_enable[1]
         && tach_min_i[15:0] != `TACH_MIN_NEVER)
      else $error("Speed status set while gated.");
   // A speed input never sets status behind an idle drive output.
   speed_duty_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      speed_status_set_o[0] && speed_input_drive_association[1:0] == 2'h0
         |-> drive_duty_i[7:0] != `DUTY_OFF && fan_enabled_i[0])
      else $error("Speed status set behind an idle drive.");
   // Soft reset runs as a write, a pulse cycle and then all defaults.
   sequence init_write_s;
      wr_en_i && !lock_i && addr_i == `DEV_CFG_OFS
         && wdata_i[`CFG_INIT_BIT];
   endsequence
   sequence init_done_s;
      soft_reset_o ##1 voltage_event_enable == `VOLT_EN_RST
         && device_configuration == `DEV_CFG_RST
         && fan_speed_event_enable == `FAN_EN_RST
         && speed_input_drive_association == `ASSOC_RST
         && temperature_event_enable == `TEMP_EN_RST;
   endsequence
   init_steps_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      init_write_s |=> init_done_s)
      else $error("Soft reset did not restore every register.");
   init_clear_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      init_pulse && !(wr_en_i && addr_i == `DEV_CFG_OFS)
         |=> device_configuration == `DEV_CFG_RST
         && !init_pulse)
      else $error("Soft reset did not restore defaults.");
   init_read_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      addr_i == `DEV_CFG_OFS |-> !rdata_o[`CFG_INIT_BIT])
      else $error("Init bit did not read as zero.");
   // An open configuration write sets the pin selects and spin-up bit.
   cfg_write_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      wr_en_i && !lock_i && addr_i == `DEV_CFG_OFS && !init_pulse
         |=> speed3_pin_as_irq_o == $past(wdata_i[`CFG_SPEED3_BIT])
         && drive2_pin_as_irq_o == $past(wdata_i[`CFG_DRIVE2_BIT])
         && spinup_shortening_enable_o
            == $past(wdata_i[`CFG_SPINUP_BIT]))
      else $error("Pin select or spin-up bit not taken.");
   assoc_write_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      wr_en_i && !lock_i && addr_i == `ASSOC_OFS && !init_pulse
         |=> speed_input_drive_association_o == $past(wdata_i))
      else $error("Association field not taken.");
   // Reserved enable bits always stay zero.
   reserved_zero_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (voltage_event_enable & ~`VOLT_EN_WMASK) == 8'h00
         && (fan_speed_event_enable & ~`FAN_EN_WMASK) == 8'h00
         && (temperature_event_enable & ~`TEMP_EN_WMASK) == 8'h00)
      else $error("Reserved enable bit set.");
   // The pin follows a request one cycle later, never without global enable.
   irq_global_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      !global_irq_output_enable_i |=> !irq_n_oe_o)
      else $error("Pin driven with global enable off.");
   irq_volt_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      global_irq_output_enable_i && v_req |=> irq_n_oe_o)
      else $error("Voltage request did not drive pin.");
   irq_speed_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      global_irq_output_enable_i && s_req |=> irq_n_oe_o)
      else $error("Speed request did not drive pin.");
   irq_temp_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      global_irq_output_enable_i && t_req |=> irq_n_oe_o)
      else $error("Temperature request did not drive pin.");
   irq_off_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      !(v_req || s_req || t_req) |=> !irq_n_oe_o)
      else $error("Pin driven without any group request.");
   ready_read_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      addr_i == `DEV_CFG_OFS
         |-> rdata_o[`CFG_READY_BIT] == thermal_readings_valid_i)
      else $error("Ready bit misread.");
   irq_any_a: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      irq_n_oe_o |-> $past(irq_req))
      else $error("Pin driven without request.");
endmodule : monitor_irq_config

// ==== src/irq_cfg_map.svh ====
// Register offsets, field positions, reset values and masks of the block.
`ifndef IRQ_CFG_MAP_SVH
`define IRQ_CFG_MAP_SVH
`define VOLT_EN_OFS     8'h7E
`define DEV_CFG_OFS     8'h7F
`define FAN_EN_OFS      8'h80
`define ASSOC_OFS       8'h81
`define TEMP_EN_OFS     8'h82
`define VOLT_EN_RST     8'hEC
`define DEV_CFG_RST     8'h10
`define FAN_EN_RST      8'h1E
`define ASSOC_RST       8'hA4
`define TEMP_EN_RST     8'h0E
`define VOLT_EN_WMASK   8'hED
`define FAN_EN_WMASK    8'h1F
`define TEMP_EN_WMASK   8'h0F
`define CFG_WMASK       8'h73
`define GROUP_EN_BIT    0
`define CFG_SPEED3_BIT  0
`define CFG_DRIVE2_BIT  1
`define CFG_READY_BIT   3
`define CFG_SPINUP_BIT  4
`define CFG_INIT_BIT    7
`define DUTY_OFF        8'h00
`define TACH_MIN_NEVER  16'hFFFF
`endif

// ==== src/irq_cfg_pkg.sv ====
// Types shared by the interrupt enable and configuration block.
package irq_cfg_pkg;
   typedef logic [7:0] reg8_t;
   typedef logic [1:0] assoc_code_t;
   typedef enum logic [1:0] {
      DRIVE_1,
      DRIVE_2,
      DRIVE_3,
      DRIVE_RSVD
   } drive_sel_t;
endpackage : irq_cfg_pkg

// ==== src/speed_event_gate.sv ====
// Per-input gate that decides whether a fan speed event may set status.
`include "irq_cfg_map.svh"
module speed_event_gate
   import irq_cfg_pkg::*;
(
   input  wire logic              event_i,
   input  wire logic              enable_i,
   input  wire irq_cfg_pkg::assoc_code_t assoc_i,
   input  wire logic [23:0]       drive_duty_i,
   input  wire logic [2:0]        fan_enabled_i,
   input  wire logic [15:0]       tach_min_i,
   output logic                   set_o
);
   // --------------------------------------------------------------
   // Suppression from the associated drive output.
   // --------------------------------------------------------------
   logic       blocked;
   logic [7:0] duty;
   logic       on;
   // Look up the associated drive and block while idle or disabled.
   always_comb begin
      duty = 8'h00;
      on   = 1'b0;
      case (drive_sel_t'(assoc_i))
         DRIVE_1: begin
            duty = drive_duty_i[7:0];
            on   = fan_enabled_i[0];
         end
         DRIVE_2: begin
            duty = drive_duty_i[15:8];
            on   = fan_enabled_i[1];
         end
         DRIVE_3: begin
            duty = drive_duty_i[23:16];
            on   = fan_enabled_i[2];
         end
         default: begin
            duty = 8'h00;
            on   = 1'b0;
         end
      endcase
      blocked = (duty == `DUTY_OFF) || !on;
   end
   // An event passes only when enabled, unblocked and the limit is live.
   assign set_o = event_i && enable_i && !blocked
                  && (tach_min_i != `TACH_MIN_NEVER);
endmodule : speed_event_gate

// ==== bench/irq_cfg_host.sv ====
// Host model that writes and addresses the block's registers byte by byte.
module irq_cfg_host (
   input  wire logic       clk_i,
   output logic            wr_en_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // The bus is idle at time zero.
   initial begin
      wr_en_o = 1'b0;
      addr_o  = 8'h00;
      wdata_o = 8'h00;
   end

   // One write pulse, held for exactly one rising edge.
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b1;
      addr_o  = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      wr_en_o = 1'b0;
      wdata_o = ~d;
   endtask : write_reg

   // Point the combinational read path at one offset.
   task automatic set_addr(input logic [7:0] a);
      @(posedge clk_i);
      #1;
      addr_o = a;
   endtask : set_addr
endmodule : irq_cfg_host

// ==== bench/monitor_interrupt_enable_config_tb.sv ====
// Self-checking bench for the interrupt enable and configuration block.
module monitor_interrupt_enable_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_cfg_pkg::*;
   logic        clk = 1'b0, reset_n = 1'b0, lock = 1'b0, gie = 1'b0;
   logic        trv = 1'b0, wr_en, hit, spinup, soft_rst, sp3, dr2;
   logic        irq_n, irq_oe;
   logic [7:0]  addr, wdata, rdata, assoc_o;
   logic [4:0]  volt_ev = 5'h00, volt_st = 5'h00, volt_set;
   logic [3:0]  speed_ev = 4'h0, speed_st = 4'h0, speed_set;
   logic [2:0]  temp_ev = 3'h0, temp_st = 3'h0, temp_set, fan_en = 3'h0;
   logic [23:0] duty = 24'h000000;
   logic [63:0] tach_min = 64'h0;
   logic [31:0] seed = 32'h56, r;
   logic [7:0]  sh_volt, sh_cfg, sh_fan, sh_assoc, sh_temp;
   int          fail_count = 0, n_tests = 0;

   irq_cfg_host irq_cfg_host_i (.clk_i(clk), .wr_en_o(wr_en),
      .addr_o(addr), .wdata_o(wdata));
   monitor_irq_config monitor_irq_config_i (.clk_i(clk),
      .reset_n_i(reset_n), .wr_en_i(wr_en), .addr_i(addr),
      .wdata_i(wdata), .rdata_o(rdata), .hit_o(hit), .lock_i(lock),
      .global_irq_output_enable_i(gie), .thermal_readings_valid_i(trv),
      .volt_event_i(volt_ev), .speed_event_i(speed_ev),
      .temp_event_i(temp_ev), .volt_status_i(volt_st),
      .speed_status_i(speed_st), .temp_status_i(temp_st),
      .drive_duty_i(duty), .fan_enabled_i(fan_en), .tach_min_i(tach_min),
      .volt_status_set_o(volt_set), .speed_status_set_o(speed_set),
      .temp_status_set_o(temp_set),
      .speed_input_drive_association_o(assoc_o),
      .spinup_shortening_enable_o(spinup), .soft_reset_o(soft_rst),
      .speed3_pin_as_irq_o(sp3), .drive2_pin_as_irq_o(dr2),
      .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));

   // Core clock of 100 MHz.
   always #5 clk = ~clk;

   // Repeatable xorshift source.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Individual voltage enables in event order.
   function automatic logic [4:0] volt_en(input logic [7:0] v);
      return {v[7], v[6], v[5], v[3], v[2]};
   endfunction : volt_en

   // The host never sends the reserved association code.
   function automatic logic [7:0] assoc_fix(input logic [7:0] v);
      for (int k = 0; k < 4; k++) begin
         v[2*k+:2] = (v[2*k+:2] == 2'h3) ? 2'h2 : v[2*k+:2];
      end
      return v;
   endfunction : assoc_fix

   // Speed events pass only with enable, live drive, enabled fan, real limit.
   function automatic logic [3:0] speed_exp();
      logic [3:0] e;
      logic [1:0] a;
      for (int n = 0; n < 4; n++) begin
         a = sh_assoc[2*n+:2];
         e[n] = speed_ev[n] & sh_fan[n+1] & (duty[8*a+:8] != 8'h00)
              & fan_en[a] & (tach_min[16*n+:16] != 16'hFFFF);
      end
      return e;
   endfunction : speed_exp

   // Pin request from global enable, group enables and enabled status.
   function automatic logic irq_exp();
      return gie & ((sh_volt[0] & |(volt_st & volt_en(sh_volt)))
                  | (sh_fan[0] & |(speed_st & sh_fan[4:1]))
                  | (sh_temp[0] & |(temp_st & sh_temp[3:1])));
   endfunction : irq_exp

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic set_defaults();
      sh_volt = 8'hEC;
      sh_cfg = 8'h10;
      sh_fan = 8'h1E;
      sh_assoc = 8'hA4;
      sh_temp = 8'h0E;
   endtask : set_defaults

   // Write through the host and track what the block should hold.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      irq_cfg_host_i.write_reg(a, d);
      if (!lock) begin
         case (a)
            8'h7E: sh_volt = d & 8'hED;
            8'h7F: sh_cfg = d & 8'h73;
            8'h80: sh_fan = d & 8'h1F;
            8'h81: sh_assoc = d;
            8'h82: sh_temp = d & 8'h0F;
            default: ;
         endcase
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      irq_cfg_host_i.set_addr(a);
      #1;
      check("rdata", exp, rdata);
      check("hit", {7'h0, a inside {[8'h7E:8'h82]}}, {7'h0, hit});
   endtask : rd

   task automatic check_regs();
      rd(8'h7E, sh_volt);
      rd(8'h7F, sh_cfg | {4'h0, trv, 3'h0});
      rd(8'h80, sh_fan);
      rd(8'h81, sh_assoc);
      rd(8'h82, sh_temp);
      rd(8'h7D, 8'h00);
      check("assoc", sh_assoc, assoc_o);
      check("spinup", {7'h0, sh_cfg[4]}, {7'h0, spinup});
      check("speed3", {7'h0, sh_cfg[0]}, {7'h0, sp3});
      check("drive2", {7'h0, sh_cfg[1]}, {7'h0, dr2});
   endtask : check_regs

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   // Watchdog well beyond the expected run of about two thousand cycles.
   initial begin
      #200000;
      fail_count++;
      print_verdict();
   end

   // Main sequence: defaults, access, lock, soft reset, random gating.
   initial begin
      repeat (20) @(posedge clk);
      #1;
      reset_n = 1'b1;
      set_defaults();
      trv = 1'b1;
      check_regs();
      wr(8'h7E, 8'hFF);
      wr(8'h7F, 8'h7F);
      wr(8'h80, 8'hFF);
      // Drive 1 is left unassociated and stays in standard mode.
      wr(8'h81, 8'h99);
      wr(8'h82, 8'hFF);
      wr(8'h7D, 8'h55);
      trv = 1'b0;
      check_regs();
      @(posedge clk);
      #1;
      lock = 1'b1;
      wr(8'h7E, 8'h00);
      wr(8'h80, 8'h00);
      wr(8'h81, 8'h00);
      wr(8'h82, 8'h00);
      wr(8'h7F, 8'h80);
      check("soft_rst", 8'h00, {7'h0, soft_rst});
      check_regs();
      @(posedge clk);
      #1;
      lock = 1'b0;
      wr(8'h7F, 8'h80);
      check("soft_rst", 8'h01, {7'h0, soft_rst});
      set_defaults();
      @(posedge clk);
      #1;
      check("soft_rst", 8'h00, {7'h0, soft_rst});
      check_regs();
      wr(8'h7F, 8'h13);
      for (int i = 0; i < 200; i++) begin
         r = rnd();
         wr(8'h7E, r[7:0]);
         wr(8'h80, r[15:8]);
         wr(8'h82, r[23:16]);
         wr(8'h81, assoc_fix(r[31:24]));
         r = rnd();
         {gie, volt_ev, speed_ev, temp_ev} = r[12:0];
         {volt_st, speed_st, temp_st, fan_en} = r[27:13];
         r = rnd();
         duty = r[23:0] & {{8{r[24]}}, {8{r[25]}}, {8{r[26]}}};
         tach_min = {rnd(), rnd()};
         tach_min[16*r[29:28]+:16] = r[30] ? 16'hFFFF : 16'h1234;
         #1;
         check("volt_set", {3'h0, volt_ev & volt_en(sh_volt)},
               {3'h0, volt_set});
         check("speed_set", {4'h0, speed_exp()},
               {4'h0, speed_set});
         check("temp_set", {5'h0, temp_ev & sh_temp[3:1]},
               {5'h0, temp_set});
         @(posedge clk);
         #1;
         check("irq_oe", {7'h0, irq_exp()},
               {7'h0, irq_oe});
         check("irq_n", 8'h00, {7'h0, irq_n});
      end
      check_regs();
      print_verdict();
   end
endmodule : monitor_interrupt_enable_config_tb
